// [shared/cfp_params.svh]
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH
`define CFP_ADDR_REC_N 8'h0B
`define CFP_ADDR_REC_SEL_M 8'h0C
`define CFP_ADDR_PROG_N 8'h0D
`define CFP_ADDR_PROG_EN_M 8'h0E
`define CFP_ADDR_VENDOR 8'h0F
`define CFP_REC_SEL_BIT 7
`define CFP_PROG_EN_BIT 7
`define CFP_RST_ZERO 8'h00
`define CFP_RST_VENDOR 8'h03
`define CFP_MASK_FULL 8'hFF
`define CFP_MASK_VENDOR 8'h03
`endif

// [shared/cfp_pkg.sv]
package cfp_pkg;
    typedef enum logic [2:0] {
        CFP_SRC_STRAP,
        CFP_SRC_SOFT,
        CFP_SRC_PROG,
        CFP_SRC_REC_STRAP,
        CFP_SRC_REC_PROG
    } cfp_src_t;
    typedef logic [7:0] cfp_byte_t;
    typedef logic [6:0] cfp_m_t;
    typedef logic [4:0] cfp_sel_t;
endpackage : cfp_pkg

// [rtl/cfp_byte_reg.sv]
`timescale 1ns/1ps
module cfp_byte_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Write side
    input wire logic we,
    input wire cfp_pkg::cfp_byte_t wdata,
    // Stored value
    output cfp_pkg::cfp_byte_t q
);
    cfp_pkg::cfp_byte_t q_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= RST_VAL;
        end else if (we) begin
            q_reg <= (wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
        end
    end

    assign q = q_reg;
endmodule : cfp_byte_reg

// [rtl/cfp_freq_ctrl.sv]
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_freq_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Byte register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire cfp_pkg::cfp_byte_t addr,
    input wire cfp_pkg::cfp_byte_t wdata,
    output cfp_pkg::cfp_byte_t rdata,
    // Frequency select inputs
    input wire cfp_pkg::cfp_sel_t strap_select_inputs,
    input wire logic strap_override,
    input wire cfp_pkg::cfp_sel_t soft_select,
    // Watchdog
    input wire logic watchdog_enable,
    input wire logic watchdog_timeout,
    // Synthesizer controls
    output cfp_pkg::cfp_byte_t cpu_n_out,
    output cfp_pkg::cfp_m_t cpu_m_out,
    output logic use_nm_terms,
    output cfp_pkg::cfp_sel_t ratio_select,
    output logic freq_load,
    output logic system_reset_req,
    output logic recovery_mode
);
    cfp_pkg::cfp_byte_t rec_n_q;
    cfp_pkg::cfp_byte_t rec_sel_m_q;
    cfp_pkg::cfp_byte_t prog_n_q;
    cfp_pkg::cfp_byte_t prog_en_m_q;
    cfp_pkg::cfp_byte_t vendor_q;
    logic we_rec_n;
    logic we_rec_sel_m;
    logic we_prog_n;
    logic we_prog_en_m;
    logic we_vendor;
    logic timeout_evt;
    logic m_load_evt;
    logic strap_taken_reg;
    cfp_pkg::cfp_sel_t strap_latched_reg;
    logic recovery_mode_reg;
    cfp_pkg::cfp_byte_t active_n_reg;
    cfp_pkg::cfp_m_t active_m_reg;
    logic freq_load_reg;
    logic system_reset_reg;
    cfp_pkg::cfp_byte_t rdata_reg;
    cfp_pkg::cfp_byte_t rdata_next;
    cfp_pkg::cfp_src_t src_next;
    cfp_pkg::cfp_byte_t cpu_n_reg;
    cfp_pkg::cfp_m_t cpu_m_reg;
    logic use_nm_reg;
    cfp_pkg::cfp_sel_t ratio_reg;
    cfp_pkg::cfp_sel_t ratio_next;

    // Programmed N/M bytes are frozen while locked in recovery; recovery bytes stay writable
    assign we_rec_n = wr_en && addr == `CFP_ADDR_REC_N;
    assign we_rec_sel_m = wr_en && addr == `CFP_ADDR_REC_SEL_M;
    assign we_prog_n = wr_en && addr == `CFP_ADDR_PROG_N
        && !recovery_mode_reg;
    assign we_prog_en_m = wr_en && addr == `CFP_ADDR_PROG_EN_M
        && !recovery_mode_reg;
    assign we_vendor = wr_en && addr == `CFP_ADDR_VENDOR;
    assign timeout_evt = watchdog_timeout && watchdog_enable
        && !recovery_mode_reg;
    assign m_load_evt = we_prog_en_m;

    cfp_byte_reg #(.RST_VAL(`CFP_RST_ZERO), .WR_MASK(`CFP_MASK_FULL))
        u_rec_n (.mclk(mclk), .nrst(nrst), .we(we_rec_n), .wdata(wdata),
        .q(rec_n_q));
    cfp_byte_reg #(.RST_VAL(`CFP_RST_ZERO), .WR_MASK(`CFP_MASK_FULL))
        u_rec_sel_m (.mclk(mclk), .nrst(nrst), .we(we_rec_sel_m),
        .wdata(wdata), .q(rec_sel_m_q));
    cfp_byte_reg #(.RST_VAL(`CFP_RST_ZERO), .WR_MASK(`CFP_MASK_FULL))
        u_prog_n (.mclk(mclk), .nrst(nrst), .we(we_prog_n), .wdata(wdata),
        .q(prog_n_q));
    cfp_byte_reg #(.RST_VAL(`CFP_RST_ZERO), .WR_MASK(`CFP_MASK_FULL))
        u_prog_en_m (.mclk(mclk), .nrst(nrst), .we(we_prog_en_m),
        .wdata(wdata), .q(prog_en_m_q));
    cfp_byte_reg #(.RST_VAL(`CFP_RST_VENDOR), .WR_MASK(`CFP_MASK_VENDOR))
        u_vendor (.mclk(mclk), .nrst(nrst), .we(we_vendor), .wdata(wdata),
        .q(vendor_q));

    // Straps caught on the first edge after reset release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            strap_taken_reg <= 1'b0;
            strap_latched_reg <= 5'h00;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            strap_latched_reg <= strap_select_inputs;
        end
    end

    // Recovery lock, held until software drops the watchdog enable
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            recovery_mode_reg <= 1'b0;
        end else if (timeout_evt) begin
            recovery_mode_reg <= 1'b1;
        end else if (!watchdog_enable) begin
            recovery_mode_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            system_reset_reg <= 1'b0;
            freq_load_reg <= 1'b0;
        end else begin
            system_reset_reg <= timeout_evt;
            freq_load_reg <= timeout_evt || m_load_evt;
        end
    end

    // N/M terms take effect only when a load starts
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active_n_reg <= 8'h00;
            active_m_reg <= 7'h00;
        end else if (timeout_evt) begin
            active_n_reg <= rec_n_q;
            active_m_reg <= rec_sel_m_q[6:0];
        end else if (m_load_evt) begin
            active_n_reg <= prog_n_q;
            active_m_reg <= wdata[6:0];
        end
    end

    always_comb begin
        if (recovery_mode_reg) begin
            if (rec_sel_m_q[`CFP_REC_SEL_BIT]) begin
                src_next = cfp_pkg::CFP_SRC_REC_PROG;
            end else begin
                src_next = cfp_pkg::CFP_SRC_REC_STRAP;
            end
        end else if (prog_en_m_q[`CFP_PROG_EN_BIT]) begin
            src_next = cfp_pkg::CFP_SRC_PROG;
        end else if (strap_override) begin
            src_next = cfp_pkg::CFP_SRC_SOFT;
        end else begin
            src_next = cfp_pkg::CFP_SRC_STRAP;
        end
    end

    always_comb begin
        if (src_next == cfp_pkg::CFP_SRC_REC_STRAP || !strap_override) begin
            ratio_next = strap_latched_reg;
        end else begin
            ratio_next = soft_select;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cpu_n_reg <= 8'h00;
            cpu_m_reg <= 7'h00;
            use_nm_reg <= 1'b0;
            ratio_reg <= 5'h00;
        end else begin
            ratio_reg <= ratio_next;
            case (src_next)
                cfp_pkg::CFP_SRC_PROG, cfp_pkg::CFP_SRC_REC_PROG: begin
                    cpu_n_reg <= active_n_reg;
                    cpu_m_reg <= active_m_reg;
                    use_nm_reg <= 1'b1;
                end
                cfp_pkg::CFP_SRC_STRAP, cfp_pkg::CFP_SRC_SOFT,
                cfp_pkg::CFP_SRC_REC_STRAP: begin
                    cpu_n_reg <= 8'h00;
                    cpu_m_reg <= 7'h00;
                    use_nm_reg <= 1'b0;
                end
                default: begin
                    cpu_n_reg <= 8'h00;
                    cpu_m_reg <= 7'h00;
                    use_nm_reg <= 1'b0;
                end
            endcase
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        case (addr)
            `CFP_ADDR_REC_N: rdata_next = rec_n_q;
            `CFP_ADDR_REC_SEL_M: rdata_next = rec_sel_m_q;
            `CFP_ADDR_PROG_N: rdata_next = prog_n_q;
            `CFP_ADDR_PROG_EN_M: rdata_next = prog_en_m_q;
            `CFP_ADDR_VENDOR: rdata_next = vendor_q;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else if (rd_en) begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign cpu_n_out = cpu_n_reg;
    assign cpu_m_out = cpu_m_reg;
    assign use_nm_terms = use_nm_reg;
    assign ratio_select = ratio_reg;
    assign freq_load = freq_load_reg;
    assign system_reset_req = system_reset_reg;
    assign recovery_mode = recovery_mode_reg;

    sequence s_timeout;
        watchdog_timeout && watchdog_enable && !recovery_mode;
    endsequence
    sequence s_reset_load;
        system_reset_req && freq_load && recovery_mode;
    endsequence
    sequence s_m_write;
        wr_en && addr == `CFP_ADDR_PROG_EN_M && !recovery_mode;
    endsequence

    AST_REC_SOURCE: assert property (
        @(posedge mclk) disable iff (!nrst)
        recovery_mode && rec_sel_m_q[`CFP_REC_SEL_BIT] |=> use_nm_terms)
        else $error("recovery source bit ignored");
    AST_REC_STRAP: assert property (
        @(posedge mclk) disable iff (!nrst)
        recovery_mode && !rec_sel_m_q[`CFP_REC_SEL_BIT] |=>
        !use_nm_terms && ratio_select == $past(strap_latched_reg))
        else $error("strap recovery source ignored");
    AST_TIMEOUT_SEQ: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_timeout |=> s_reset_load)
        else $error("time-out did not reset and load");
    AST_REC_TERMS: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_timeout and rec_sel_m_q[`CFP_REC_SEL_BIT] |=> ##1
        cpu_n_out == $past(rec_n_q, 2) && use_nm_terms)
        else $error("recovery N not applied");
    AST_RATIO: assert property (
        @(posedge mclk) disable iff (!nrst)
        !recovery_mode && strap_override |=>
        ratio_select == $past(soft_select))
        else $error("software ratio not used");
    AST_PROG_M_LOAD: assert property (
        @(posedge mclk) disable iff (!nrst)
        s_m_write |=> freq_load ##1
        cpu_m_out == $past(wdata[6:0], 2)
        || !prog_en_m_q[`CFP_PROG_EN_BIT])
        else $error("programmed M not loaded");
    AST_LOAD_ONLY_M: assert property (
        @(posedge mclk) disable iff (!nrst)
        wr_en && addr == `CFP_ADDR_PROG_N && !watchdog_timeout |=>
        !freq_load)
        else $error("load started by N write");
    AST_PROG_DISABLED: assert property (
        @(posedge mclk) disable iff (!nrst)
        !recovery_mode && !prog_en_m_q[`CFP_PROG_EN_BIT] |=> !use_nm_terms)
        else $error("programmed terms used while disabled");
    AST_VENDOR: assert property (
        @(posedge mclk) disable iff (!nrst)
        vendor_q[7:2] == 6'h00)
        else $error("vendor byte upper bits set");
    AST_LOCK: assert property (
        @(posedge mclk) disable iff (!nrst)
        recovery_mode && watchdog_enable |=> $stable(prog_en_m_q)
        && recovery_mode)
        else $error("frequency write accepted while locked");
    AST_STRAP_FOLLOW: assert property (
        @(posedge mclk) disable iff (!nrst)
        !recovery_mode && !strap_override && strap_taken_reg |=>
        ratio_select == strap_latched_reg)
        else $error("strap ratio not followed");
    AST_UNMAPPED: assert property (
        @(posedge mclk) disable iff (!nrst)
        rd_en && addr > `CFP_ADDR_VENDOR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : cfp_freq_ctrl

// [sim/cfp_host_model.sv]
`timescale 1ns/1ps
module cfp_host_model (
    // Clock
    input wire logic mclk,
    // Byte port
    output logic wr_en,
    output logic rd_en,
    output cfp_pkg::cfp_byte_t addr,
    output cfp_pkg::cfp_byte_t wdata,
    input wire cfp_pkg::cfp_byte_t rdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    task automatic wr(input cfp_pkg::cfp_byte_t a,
                      input cfp_pkg::cfp_byte_t d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : wr

    task automatic rd(input cfp_pkg::cfp_byte_t a,
                      output cfp_pkg::cfp_byte_t d);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        #1;
        d = rdata;
    endtask : rd

    // N first, M last; the M write starts the load
    task automatic set_nm(input cfp_pkg::cfp_byte_t n,
                          input cfp_pkg::cfp_m_t m,
                          input logic en);
        wr(8'h0D, n);
        wr(8'h0E, {en, m});
    endtask : set_nm

    // Test bits always written as ones
    task automatic wr_vendor(input cfp_pkg::cfp_byte_t d);
        wr(8'h0F, d | 8'h03);
    endtask : wr_vendor
endmodule : cfp_host_model

// [sim/tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en, rd_en, strap_override, watchdog_enable, watchdog_timeout;
    logic use_nm_terms, freq_load, system_reset_req, recovery_mode;
    cfp_pkg::cfp_byte_t addr, wdata, rdata, cpu_n_out, rd_v, n_v;
    cfp_pkg::cfp_m_t cpu_m_out, m_v;
    cfp_pkg::cfp_sel_t straps, soft_select, ratio_select, latched;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_load = 0;
    int n_rst = 0;
    int l0;

    always #2 mclk = ~mclk;

    cfp_freq_ctrl dut (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata),
        .strap_select_inputs(straps), .strap_override(strap_override),
        .soft_select(soft_select), .watchdog_enable(watchdog_enable),
        .watchdog_timeout(watchdog_timeout), .cpu_n_out(cpu_n_out),
        .cpu_m_out(cpu_m_out), .use_nm_terms(use_nm_terms),
        .ratio_select(ratio_select), .freq_load(freq_load),
        .system_reset_req(system_reset_req), .recovery_mode(recovery_mode));

    cfp_host_model host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata));

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    always @(posedge mclk) begin
        cyc++;
        if (freq_load === 1'b1) n_load++;
        if (system_reset_req === 1'b1) n_rst++;
        if (cyc > 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    function automatic cfp_pkg::cfp_sel_t exp_ratio();
        return strap_override ? soft_select : latched;
    endfunction : exp_ratio

    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic chk_out(input cfp_pkg::cfp_byte_t n,
                           input cfp_pkg::cfp_m_t m,
                           input logic u, input cfp_pkg::cfp_sel_t r);
        `CHK(cpu_n_out, n)
        `CHK(cpu_m_out, m)
        `CHK(use_nm_terms, u)
        `CHK(ratio_select, r)
    endtask : chk_out

    task automatic pulse_timeout;
        @(posedge mclk);
        watchdog_timeout <= 1'b1;
        @(posedge mclk);
        watchdog_timeout <= 1'b0;
        settle();
    endtask : pulse_timeout

    initial begin
        void'($urandom(32'hd3178eb8));
        strap_override = 1'b0;
        soft_select = 5'h00;
        watchdog_enable = 1'b0;
        watchdog_timeout = 1'b0;
        latched = 5'($urandom);
        straps = latched;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        straps <= ~latched;
        for (int a = 11; a <= 15; a++) begin
            host.rd(8'(a), rd_v);
            `CHK(rd_v, (a == 15) ? 8'h03 : 8'h00)
        end
        chk_out(8'h00, 7'h00, 1'b0, latched);
        $display("test reset done");
        repeat (4) begin
            n_v = $urandom;
            m_v = $urandom;
            @(posedge mclk);
            strap_override <= $urandom;
            soft_select <= $urandom;
            l0 = n_load;
            host.set_nm(n_v, m_v, 1'b1);
            settle();
            `CHK(n_load, l0 + 1)
            chk_out(n_v, m_v, 1'b1, exp_ratio());
            host.rd(8'h0E, rd_v);
            `CHK(rd_v, {1'b1, m_v})
        end
        host.set_nm(n_v, m_v, 1'b0);
        settle();
        chk_out(8'h00, 7'h00, 1'b0, exp_ratio());
        $display("test program done");
        host.wr_vendor(8'hFC);
        host.rd(8'h0F, rd_v);
        `CHK(rd_v, 8'h03)
        host.wr_vendor(8'hFF);
        host.rd(8'h0F, rd_v);
        `CHK(rd_v, 8'h03)
        host.wr(8'h10, 8'($urandom));
        host.rd(8'h10, rd_v);
        `CHK(rd_v, 8'h00)
        $display("test reserved done");
        l0 = n_rst;
        pulse_timeout();
        `CHK(n_rst, l0)
        `CHK(recovery_mode, 1'b0)
        host.wr(8'h0C, {1'b0, 7'h2A});
        @(posedge mclk);
        watchdog_enable <= 1'b1;
        strap_override <= 1'b1;
        pulse_timeout();
        `CHK(n_rst, l0 + 1)
        `CHK(recovery_mode, 1'b1)
        chk_out(8'h00, 7'h00, 1'b0, latched);
        host.wr(8'h0E, 8'hFF);
        host.rd(8'h0E, rd_v);
        `CHK(rd_v, {1'b0, m_v})
        pulse_timeout();
        `CHK(n_rst, l0 + 1)
        @(posedge mclk);
        watchdog_enable <= 1'b0;
        settle();
        `CHK(recovery_mode, 1'b0)
        $display("test strap recovery done");
        n_v = $urandom;
        m_v = $urandom;
        host.wr(8'h0B, n_v);
        host.wr(8'h0C, {1'b1, m_v});
        @(posedge mclk);
        watchdog_enable <= 1'b1;
        pulse_timeout();
        `CHK(cpu_n_out, n_v)
        `CHK(cpu_m_out, m_v)
        `CHK(use_nm_terms, 1'b1)
        @(posedge mclk);
        watchdog_enable <= 1'b0;
        $display("test program recovery done");
        complete_run();
    end
endmodule : tb
